// [design/sld_seq.sv]
// speaker load diagnostic sequencer: runs the load check, holds the bridge in
// high impedance while checking and reports the result.
// assumes comparator inputs from the analogue load sense and fault monitors,
// all from outside this clock domain, and one core clock
//
// Functional notes
// R1: start on hold release or protection fault
// R2: bridge outputs high impedance during run
// R3: classify ground, rail, open, shorted, normal
// R4: a full run lasts about 229 ms
// R5: repeat check phase up to five times
// R6: open load still enables audio output
// R7: other faults hold high impedance, recheck
// R8: normal result starts audio output
// R9: after overvoltage, run only every second event
// R10: open load reported in status only
// R11: shorts reported in status and error pin
// R12: thermal or supply fault aborts run immediately
// R13: status flags hold until next run
module sld_seq
	import sld_pkg::*;
#(
	parameter longint CHECK_LEN = sld_pkg::CHECK_CYCLES,
	parameter int CHECK_PASSES = sld_pkg::CHECK_MAX
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic hold_n,
	input wire logic fault_dc,
	input wire logic fault_oc,
	input wire logic fault_ov,
	input wire logic fault_uv,
	input wire logic fault_ot,
	input wire logic sense_gnd,
	input wire logic sense_rail,
	input wire logic sense_short,
	input wire logic sense_open,
	input wire logic sense_bigcap,
	output logic bridge_hiz,
	output logic audio_en,
	output logic diag_busy,
	output logic [2:0] diag_result,
	output logic stat_gnd,
	output logic stat_rail,
	output logic stat_short,
	output logic stat_open,
	output logic error_pin_o,
	output logic error_pin_oe_n
);
	localparam int NIN = 11;
	localparam int CW = 40;

	// refuse a check length the counter cannot hold or a pass count beyond four bits
	if (CHECK_LEN < 1 || CHECK_LEN > (longint'(1) << CW) ||
		CHECK_PASSES < 1 || CHECK_PASSES > 15) begin : g_bad_param
		$error("sld_seq: bad parameters");
	end

	// reset release through two flip-flops
	logic rst_s1, rst_n;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// three-stage synchronisers, a change counts when stages two and three agree
	logic [NIN-1:0] raw, s1, s2, s3, in_r, in_nxt;
	assign raw = {sense_bigcap, sense_open, sense_short, sense_rail, sense_gnd,
		fault_ot, fault_uv, fault_ov, fault_oc, fault_dc, hold_n};
	always_comb begin
		in_nxt = in_r;
		for (int i = 0; i < NIN; i++) begin
			if (s2[i] == s3[i]) begin
				in_nxt[i] = s3[i];
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			in_r <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			in_r <= in_nxt;
		end
	end

	logic hold_q, f_dc, f_oc, f_ov, f_uv, f_ot, c_gnd, c_rail, c_short, c_open, c_cap;
	assign {c_cap, c_open, c_short, c_rail, c_gnd, f_ot, f_uv, f_ov, f_oc, f_dc, hold_q} =
		in_r;

	// classify the sensed load, shorts take priority over open
	function automatic sld_res_t classify(input logic g, input logic r,
		input logic s, input logic o);
		if (g) begin
			return SLD_RES_GND;
		end else if (r) begin
			return SLD_RES_RAIL;
		end else if (s) begin
			return SLD_RES_SHORT;
		end else if (o) begin
			return SLD_RES_OPEN;
		end
		return SLD_RES_NORMAL;
	endfunction : classify

	sld_state_t st_r, st_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [3:0] pass_r, pass_nxt;
	logic hold_d_r, ov_d_r, ov_par_r, ov_par_nxt;
	logic pend_r, pend_nxt;
	logic [2:0] res_r, res_nxt;
	logic [3:0] stat_r, stat_nxt;
	logic abort, hold_rise, ov_rise, other_fault, start;
	sld_res_t cls;

	assign abort = f_ot | f_ov | f_uv;
	assign hold_rise = hold_q & ~hold_d_r;
	assign ov_rise = f_ov & ~ov_d_r;
	assign other_fault = f_dc | f_oc | f_uv | f_ot;
	assign cls = classify(c_gnd, c_rail, c_short, c_open);
	// supply and thermal faults block a start, so their runs wait in pend_r
	assign start = hold_rise | pend_r | f_dc | f_oc; // R1 R9

	// sequencer next state
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		pass_nxt = pass_r;
		res_nxt = res_r;
		stat_nxt = stat_r;
		ov_par_nxt = ov_par_r;
		pend_nxt = pend_r;
		if (ov_rise) begin
			ov_par_nxt = ~ov_par_r; // R9
		end
		case (st_r)
			SLD_IDLE, SLD_PLAY: begin
				if (!hold_q) begin
					st_nxt = SLD_IDLE;
				end else if (start && !abort) begin
					st_nxt = SLD_CHECK; // R1
					cnt_nxt = '0;
					pass_nxt = 4'h1;
				end else if (st_r == SLD_IDLE && hold_q && !abort && !other_fault) begin
					st_nxt = SLD_PLAY;
				end
			end
			SLD_CHECK: begin
				if (abort || !hold_q) begin
					st_nxt = SLD_IDLE; // R12
				end else if (cnt_r == CW'(CHECK_LEN - 1)) begin
					cnt_nxt = '0;
					if ((cls != SLD_RES_NORMAL && cls != SLD_RES_OPEN || c_cap)
						&& pass_r < 4'(CHECK_PASSES)) begin
						pass_nxt = pass_r + 4'h1; // R5 R4
					end else begin
						st_nxt = SLD_JUDGE;
					end
				end else begin
					cnt_nxt = cnt_r + CW'(1);
				end
			end
			SLD_JUDGE: begin
				res_nxt = cls; // R3
				stat_nxt = {cls == SLD_RES_OPEN, cls == SLD_RES_SHORT,
					cls == SLD_RES_RAIL, cls == SLD_RES_GND}; // R13
				if (cls == SLD_RES_NORMAL || cls == SLD_RES_OPEN) begin
					st_nxt = SLD_PLAY; // R6 R8
				end else begin
					st_nxt = SLD_HOLD; // R7
				end
			end
			SLD_HOLD: begin
				if (abort || !hold_q) begin
					st_nxt = SLD_IDLE;
				end else begin
					st_nxt = SLD_CHECK; // R7
					cnt_nxt = '0;
					pass_nxt = 4'h1;
				end
			end
			default: st_nxt = SLD_IDLE;
		endcase
		// a pending run is served once the sequencer enters a check
		if (st_nxt == SLD_CHECK && st_r != SLD_CHECK) begin
			pend_nxt = 1'b0;
		end
		// a new fault wins over the clear in the same cycle
		if (f_uv || f_ot || (ov_rise && ov_par_r)) begin
			pend_nxt = 1'b1; // R1 R9
		end
	end

	// sequencer registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= SLD_IDLE;
			cnt_r <= '0;
			pass_r <= 4'h0;
			res_r <= SLD_RES_NORMAL;
			stat_r <= 4'h0;
			hold_d_r <= 1'b0;
			ov_d_r <= 1'b0;
			ov_par_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			pass_r <= pass_nxt;
			res_r <= res_nxt;
			stat_r <= stat_nxt;
			hold_d_r <= hold_q;
			ov_d_r <= f_ov;
			ov_par_r <= ov_par_nxt;
			pend_r <= pend_nxt;
		end
	end

	// output registers
	logic hiz_r, aud_r, busy_r, err_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hiz_r <= 1'b1;
			aud_r <= 1'b0;
			busy_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			hiz_r <= (st_nxt != SLD_PLAY); // R2 R7
			aud_r <= (st_nxt == SLD_PLAY); // R6 R8
			busy_r <= (st_nxt == SLD_CHECK || st_nxt == SLD_JUDGE);
			err_r <= |stat_nxt[2:0]; // R10 R11
		end
	end

	assign bridge_hiz = hiz_r;
	assign audio_en = aud_r;
	assign diag_busy = busy_r;
	assign diag_result = res_r;
	assign {stat_open, stat_short, stat_rail, stat_gnd} = stat_r;
	assign error_pin_o = 1'b0;
	assign error_pin_oe_n = ~err_r; // open drain: low enable pulls pin low
endmodule : sld_seq

// [design/sld_pkg.sv]
// package for the speaker load diagnostic sequencer
// assumes a single 100 MHz core clock
package sld_pkg;
	localparam int CLK_MHZ = 100;
	// full run length in milliseconds and the derived cycle count
	localparam int RUN_MS = 229;
	localparam longint RUN_CYCLES = longint'(RUN_MS) * 1000 * CLK_MHZ;
	// number of check passes allowed in one run
	localparam int CHECK_MAX = 5;
	// check pass length: the run time is shared among the passes
	localparam longint CHECK_CYCLES = RUN_CYCLES / CHECK_MAX;
	// result codes
	typedef enum logic [2:0] {
		SLD_RES_NORMAL = 3'h0,
		SLD_RES_GND = 3'h1,
		SLD_RES_RAIL = 3'h2,
		SLD_RES_SHORT = 3'h3,
		SLD_RES_OPEN = 3'h4
	} sld_res_t;
	typedef enum logic [2:0] {
		SLD_IDLE,
		SLD_CHECK,
		SLD_JUDGE,
		SLD_PLAY,
		SLD_HOLD
	} sld_state_t;
endpackage : sld_pkg

// [testbench/sld_seq_properties.sv]
// checker for the load diagnostic sequencer
// bound to sld_seq, sees its ports only
module sld_seq_properties
	import sld_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic hold_n,
	input wire logic fault_ov,
	input wire logic fault_uv,
	input wire logic fault_ot,
	input wire logic diag_busy,
	input wire logic bridge_hiz,
	input wire logic audio_en,
	input wire logic [2:0] diag_result,
	input wire logic error_pin_oe_n
);
	logic was_r, end_w, flt_w;
	// busy one cycle back
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			was_r <= 1'h0;
		end else begin
			was_r <= diag_busy;
		end
	end
	// run ended without an abort by fault or hold
	assign end_w = was_r && !diag_busy && hold_n && !fault_ot && !fault_ov && !fault_uv;
	assign flt_w = end_w && diag_result inside {SLD_RES_GND, SLD_RES_RAIL, SLD_RES_SHORT};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	busy_hiz_a: assert property (diag_busy |-> bridge_hiz) else $error("drive");
	play_drive_a: assert property (audio_en |-> !bridge_hiz) else $error("hiz");
	run_min_a: assert property ($rose(diag_busy)
		|-> (diag_busy || !hold_n || fault_ot || fault_ov || fault_uv) [*8]) else $error("short");
	open_pin_a: assert property (end_w && diag_result == SLD_RES_OPEN
		|-> ##[0:2] error_pin_oe_n) else $error("pin set");
	run_abort_a: assert property (diag_busy && fault_ot |-> ##[1:10] !diag_busy)
		else $error("abort");
	play_ok_a: assert property (end_w && diag_result inside {SLD_RES_NORMAL, SLD_RES_OPEN}
		|-> ##[0:2] audio_en) else $error("play");
	flt_pin_a: assert property (flt_w |-> ##[0:2] !error_pin_oe_n) else $error("pin");
	flt_hiz_a: assert property (flt_w |-> !audio_en [*4]) else $error("on");
	stat_hold_a: assert property (!diag_busy && !was_r |-> $stable(diag_result))
		else $error("moved");
endmodule : sld_seq_properties

bind sld_seq sld_seq_properties sld_seq_properties_i (
	.core_clk(core_clk),
	.rstn(rstn),
	.hold_n(hold_n),
	.fault_ov(fault_ov),
	.fault_uv(fault_uv),
	.fault_ot(fault_ot),
	.diag_busy(diag_busy),
	.bridge_hiz(bridge_hiz),
	.audio_en(audio_en),
	.diag_result(diag_result),
	.error_pin_oe_n(error_pin_oe_n)
);

// [testbench/sld_load_model.sv]
// speaker load model on the bridge outputs
// comparators answer only while the bridge is biased
module sld_load_model (
	input wire logic bridge_hiz,
	input wire logic [2:0] load_kind,
	input wire logic bigcap,
	output logic sense_gnd,
	output logic sense_rail,
	output logic sense_short,
	output logic sense_open,
	output logic sense_bigcap
);
	// kind 1 to 4 lights one comparator, kind 0 is a good load
	assign {sense_open, sense_short, sense_rail, sense_gnd} =
		bridge_hiz ? 4'((5'h1 << load_kind) >> 1) : 4'h0;
	// large capacitance to ground shows only while the output is biased
	assign sense_bigcap = bridge_hiz & bigcap;
endmodule : sld_load_model

// [testbench/sld_seq_bench.sv]
// bench for the load diagnostic sequencer
// load model on the far side, inputs change at falling edges
module sld_seq_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import sld_pkg::*;
	// short check pass so that a full five-pass run stays quick
	localparam int LEN = 20;
	logic core_clk = 1'h0, rstn = 1'h0, hold_n = 1'h0, fault_ov = 1'h0, fault_ot = 1'h0;
	logic fault_dc = 1'h0, fault_oc = 1'h0, fault_uv = 1'h0, bigcap = 1'h0;
	logic [2:0] load_kind = 3'h0, diag_result;
	logic sense_gnd, sense_rail, sense_short, sense_open, sense_bigcap, bridge_hiz, audio_en;
	logic diag_busy, stat_gnd, stat_rail, stat_short, stat_open, error_pin_o, error_pin_oe_n;
	int n_fail = 0, checks_done = 0, seed = 88589, i, t;
	sld_res_t exp_tab[5] = '{SLD_RES_NORMAL, SLD_RES_GND, SLD_RES_RAIL, SLD_RES_SHORT, SLD_RES_OPEN};
	always #5 core_clk = ~core_clk;
	sld_seq #(.CHECK_LEN(LEN), .CHECK_PASSES(CHECK_MAX)) sld_seq_i (
		.core_clk(core_clk),
		.rstn(rstn),
		.hold_n(hold_n),
		.fault_dc(fault_dc),
		.fault_oc(fault_oc),
		.fault_ov(fault_ov),
		.fault_uv(fault_uv),
		.fault_ot(fault_ot),
		.sense_gnd(sense_gnd),
		.sense_rail(sense_rail),
		.sense_short(sense_short),
		.sense_open(sense_open),
		.sense_bigcap(sense_bigcap),
		.bridge_hiz(bridge_hiz),
		.audio_en(audio_en),
		.diag_busy(diag_busy),
		.diag_result(diag_result),
		.stat_gnd(stat_gnd),
		.stat_rail(stat_rail),
		.stat_short(stat_short),
		.stat_open(stat_open),
		.error_pin_o(error_pin_o),
		.error_pin_oe_n(error_pin_oe_n)
	);
	sld_load_model sld_load_model_i (
		.bridge_hiz(bridge_hiz),
		.load_kind(load_kind),
		.bigcap(bigcap),
		.sense_gnd(sense_gnd),
		.sense_rail(sense_rail),
		.sense_short(sense_short),
		.sense_open(sense_open),
		.sense_bigcap(sense_bigcap)
	);
	// count one comparison, an unknown counts as a mismatch
	task automatic check(input logic ok);
		checks_done++;
		if (ok !== 1'h1) begin
			n_fail++;
			$display("mismatch at %0t: check %0d", $time, checks_done);
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	// bounded wait for the busy flag
	task automatic wait_busy(input logic lvl, input int lim);
		for (t = 0; t < lim && diag_busy !== lvl; t++) @(negedge core_clk);
		check(diag_busy === lvl);
		if (diag_busy !== lvl) close_out();
	endtask : wait_busy
	task automatic start(input int k);
		hold_n = 1'h0;
		repeat (12) @(negedge core_clk);
		load_kind = 3'(k);
		hold_n = 1'h1;
		wait_busy(1'h1, 20);
	endtask : start
	task automatic run(input int k);
		int exp_len;
		// a ground, rail or short fault or a large capacitance uses every pass, a clean or open load only one
		exp_len = (k inside {1, 2, 3} || bigcap) ? LEN * CHECK_MAX : LEN;
		start(k);
		wait_busy(1'h0, 400);
		check(t >= exp_len && t <= exp_len + 2);
		repeat (3) @(negedge core_clk);
		check(diag_busy === (k inside {1, 2, 3}));
		check(diag_result === exp_tab[k]);
		check(error_pin_oe_n === !(k inside {1, 2, 3}));
		check(audio_en === (k == 0 || k == 4));
		check(stat_open === (k == 4));
		$display("load %0d done", k);
	endtask : run
	initial begin
		repeat (5) @(negedge core_clk);
		rstn = 1'h1;
		// every load kind, then random ones
		for (i = 0; i < 9; i++) run(i < 5 ? i : {$random(seed)} % 5);
		// large capacitance keeps the check repeating before the load is judged
		bigcap = 1'h1;
		run(0);
		run(4);
		bigcap = 1'h0;
		// thermal fault part way through a run
		start(0);
		repeat (10) @(negedge core_clk);
		fault_ot = 1'h1;
		wait_busy(1'h0, 10);
		fault_ot = 1'h0;
		$display("thermal abort done");
		run(0);
		// dc detect, then overcurrent, while playing starts a run
		for (i = 0; i < 2; i++) begin
			if (i == 0) begin
				fault_dc = 1'h1;
			end else begin
				fault_oc = 1'h1;
			end
			wait_busy(1'h1, 20);
			fault_dc = 1'h0;
			fault_oc = 1'h0;
			wait_busy(1'h0, 400);
			repeat (3) @(negedge core_clk);
			check(audio_en === 1'h1);
			$display("fault %0d run done", i);
		end
		// undervoltage holds the run back until the supply recovers
		fault_uv = 1'h1;
		repeat (10) @(negedge core_clk);
		check(diag_busy === 1'h0);
		fault_uv = 1'h0;
		wait_busy(1'h1, 20);
		wait_busy(1'h0, 400);
		$display("undervoltage run done");
		// only the second overvoltage event starts a run
		for (i = 0; i < 2; i++) begin
			fault_ov = 1'h1;
			repeat (10) @(negedge core_clk);
			fault_ov = 1'h0;
			for (t = 0; t < 30 && diag_busy !== 1'h1; t++) @(negedge core_clk);
			check(diag_busy === (i == 1));
			wait_busy(1'h0, 400);
		end
		$display("overvoltage runs done");
		close_out();
	end
endmodule : sld_seq_bench
